// File: bench/mqfc_link_properties.sv
// Checker for the write-select and full-flag link between both ends
`timescale 1ns/1ns
`default_nettype none
module mqfc_link_properties (
   // Clock and reset
   input wire logic       clk,
   input wire logic       srst,
   // Write and read requests
   input wire logic [5:0] write_queue_address,
   input wire logic       write_address_enable,
   input wire logic       write_enable,
   input wire logic       read_enable,
   input wire logic       almost_full_bus_strobe,
   input wire logic       master_reset,
   // Flag, straps and bus ownership
   input wire logic       full_flag_o,
   input wire logic       full_flag_oe,
   input wire logic       full_line,
   input wire logic       chip_code_pin0,
   input wire logic       chip_code_pin1,
   input wire logic       chip_code_pin2,
   input wire logic       almost_full_bus_owner
);
   logic [2:0] code;
   assign code = {chip_code_pin2, chip_code_pin1, chip_code_pin0};
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_sel_here;
      write_address_enable && write_queue_address[5:3] == code;
   endsequence
   sequence s_sel_away;
      write_address_enable && write_queue_address[5:3] != code;
   endsequence
   AST_SEL_DRIVES: assert property (s_sel_here |=> full_flag_oe)
      else $error("flag not driven after local select");
   AST_SEL_RELEASES: assert property (s_sel_away |=> !full_flag_oe)
      else $error("flag still driven after foreign select");
   AST_OE_HOLDS: assert property (!write_address_enable && !master_reset |=> full_flag_oe == $past(full_flag_oe))
      else $error("flag drive changed without select");
   AST_OWNER: assert property (almost_full_bus_owner == (almost_full_bus_strobe && write_queue_address[5:3] == code))
      else $error("almost-full bus owner wrong");
   AST_NO_EARLY_WRITE: assert property (write_address_enable |=> !write_enable)
      else $error("write one edge after select");
   AST_NO_WRITE_FULL: assert property (write_enable |-> full_line)
      else $error("write issued while line shows full");
   // With the line held and no select, the flag falls only after a write and rises only after a read or master reset
   AST_FALL_CAUSE: assert property ($fell(full_flag_o) && full_flag_oe && $past(full_flag_oe) && !$past(write_address_enable)
      |-> $past(write_enable) || $past(write_enable, 2))
      else $error("full flag fell without write");
   AST_RISE_CAUSE: assert property ($rose(full_flag_o) && full_flag_oe && $past(full_flag_oe) && !$past(write_address_enable)
      |-> $past(read_enable) || $past(read_enable, 2) || $past(master_reset))
      else $error("full flag rose without read");
endmodule
`default_nettype wire

// File: bench/multiqueue_write_select_full_flag_tb_top.sv
// Bench driving the host over Avalon against the eight-queue device
`timescale 1ns/1ns
`default_nettype none
module multiqueue_write_select_full_flag_tb_top;
   localparam int         DEPTH = 4;
   localparam logic [2:0] CODE  = 3'h5;
   logic        clk;
   logic        srst;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        owner;
   logic [9:0]  mode;
   logic [5:0]  cq;
   logic [35:0] lw;
   logic [31:0] q;
   logic [31:0] u;
   int          error_cnt;
   int          comparisons;
   int          win [5]  = '{36, 36, 36, 18, 9};
   int          wout [5] = '{36, 18, 9, 36, 36};
   logic [9:0]  mtab [5] = '{10'h000, 10'h040, 10'h140, 10'h0C0, 10'h1C0};
   mqfc_link_if link ();
   mqfc_host mqfc_host_inst (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .link(link));
   // Straps fixed: one device on the bus, foreign codes exercise release
   mqfc_device #(.DEPTH(DEPTH)) mqfc_device_inst (.clk(clk), .srst(srst), .link(link),
      .chip_code_pin0(CODE[0]), .chip_code_pin1(CODE[1]), .chip_code_pin2(CODE[2]),
      .almost_full_bus_owner(owner));
   mqfc_link_properties mqfc_link_properties_inst (.clk(clk), .srst(srst),
      .write_queue_address(link.write_queue_address), .write_address_enable(link.write_address_enable),
      .write_enable(link.write_enable), .read_enable(link.read_enable),
      .almost_full_bus_strobe(link.almost_full_bus_strobe), .master_reset(link.master_reset),
      .full_flag_o(link.full_flag_o), .full_flag_oe(link.full_flag_oe), .full_line(link.full_line),
      .chip_code_pin0(CODE[0]), .chip_code_pin1(CODE[1]), .chip_code_pin2(CODE[2]),
      .almost_full_bus_owner(owner));
   task automatic summarize();
      $display("Counts: %0d compared, %0d mismatched", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chkd(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t data %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chko(input logic exp);
      @(negedge clk);
      comparisons++;
      if (owner !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t bus owner %b", $time, owner);
      end
   endtask
   // Link pulses reach the device one edge after the bus completes
   task automatic chkf(input logic exp_line, input logic exp_oe);
      @(posedge clk);
      @(negedge clk);
      comparisons++;
      if (link.full_line !== exp_line || link.full_flag_oe !== exp_oe)
      begin
         error_cnt++;
         $display("MISMATCH %0t flag line %b drive %b", $time, link.full_line, link.full_flag_oe);
      end
   endtask
   // Idle cycle between requests keeps each strobe to one assignment per step
   task automatic av(input logic rd, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address   <= a;
      avs_read      <= rd;
      avs_write     <= !rd;
      avs_writedata <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
      begin
         error_cnt++;
         summarize();
      end
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
      av(1'b1, a, 32'h0000_0000);
      chkd(q & m, exp);
   endtask
   task automatic ctl(input logic [5:0] qa, input logic [9:0] b);
      av(1'b0, 4'h0, {16'h0000, mode | b, qa});
      // Read data reaches the host's capture register two edges later
      if (b[4])
         repeat (2) @(posedge clk);
   endtask
   task automatic sel(input logic [5:0] qa);
      cq = qa;
      ctl(cq, 10'h004);
   endtask
   task automatic push(input logic [31:0] d);
      av(1'b0, 4'h8, d);
      ctl(cq, 10'h008);
   endtask
   task automatic setup(input logic [9:0] m, input logic [2:0] qn);
      mode = m;
      ctl(6'h00, 10'h200);
      ctl(6'h00, 10'h000);
      sel({CODE, qn});
   endtask
   function automatic logic [31:0] lane(input logic [35:0] v, input int w, input int j);
      logic [35:0] t;
      t = (v >> (w * j)) & (36'hF_FFFF_FFFF >> (36 - w));
      return t[31:0];
   endfunction
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      srst = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      mode = 10'h000;
      cq = 6'h00;
      error_cnt = 0;
      comparisons = 0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      rdchk(4'h4, 32'h0000_0001, 32'h0000_0000);
      rdchk(4'h2, 32'hFFFF_FFFF, 32'h0000_0000);
      chkf(1'b1, 1'b0);
      $display("Test reset done");
      setup(10'h000, 3'h0);
      chkf(1'b1, 1'b1);
      for (int i = 0; i < DEPTH; i++)
         push(32'h1000_0000 + i);
      rdchk(4'h4, 32'h0000_0001, 32'h0000_0001);
      chkf(1'b0, 1'b1);
      push(32'hDEAD_BEEF);
      sel({CODE, 3'h1});
      chkf(1'b1, 1'b1);
      sel({~CODE, 3'h0});
      chkf(1'b1, 1'b0);
      ctl(cq, 10'h020);
      chko(1'b0);
      sel({CODE, 3'h0});
      chkf(1'b0, 1'b1);
      ctl(cq, 10'h020);
      chko(1'b1);
      ctl(cq, 10'h010);
      rdchk(4'hC, 32'hFFFF_FFFF, 32'h1000_0000);
      chkf(1'b1, 1'b1);
      push(32'h2000_0000);
      chkf(1'b0, 1'b1);
      $display("Test select and fill done");
      setup(10'h140, 3'h3);
      for (int i = 0; i < DEPTH; i++)
         push(32'h8765_4321);
      for (int k = 0; k < 4; k++)
      begin
         ctl(cq, 10'h010);
         rdchk(4'hC, 32'hFFFF_FFFF, lane(36'h0_8765_4321, 9, k));
         rdchk(4'h4, 32'h0000_0001, {31'h0, k < 3});
      end
      $display("Test narrow read of full queue done");
      for (int m = 0; m < 5; m++)
      begin
         setup(mtab[m], 3'h4);
         lw = '0;
         for (int i = 0; i < 36 / win[m]; i++)
         begin
            u = lane({4'h0, 32'h1357_9BDF ^ (32'h0F0F_0F0F << i)}, win[m], 0);
            lw = lw | ({4'h0, u} << (i * win[m]));
            push(u);
         end
         for (int j = 0; j < 36 / wout[m]; j++)
         begin
            ctl(cq, 10'h010);
            rdchk(4'hC, 32'hFFFF_FFFF, lane(lw, wout[m], j));
         end
      end
      $display("Test width matching modes done");
      summarize();
   end
endmodule
`default_nettype wire

// File: logic/mqfc_defs.svh
// Constants for the multi-queue write-select and full-flag block
`ifndef MQFC_DEFS_SVH
`define MQFC_DEFS_SVH
`define MQFC_QADDR_W      6
`define MQFC_QSEL_W       3
`define MQFC_NQUEUE       8
`define MQFC_LONG_W       36
`define MQFC_DEPTH        16
`define MQFC_PTR_W        4
`define MQFC_CHIP_CODE    3'h0
`define MQFC_CSR_CTRL     4'h0
`define MQFC_CSR_STATUS   4'h4
`define MQFC_CSR_WDATA    4'h8
`define MQFC_CSR_RDATA    4'hC
`endif

// File: logic/mqfc_device.sv
// Eight-queue device: write queue select, bus matching and full flag
// Overview of operation
// - Six-bit write address, low three pick queue
// - Selected only when upper bits match chip code
// - At most eight devices, unique codes, 64 queues
// - Write address plus strobe address almost-full bus
// - Widths sampled from three pins at master reset
// - One port must stay 36 bits wide
// - Narrow units packed little-endian in long words
// - Full status counted in write-width units
// - Valid status counted in read-width units
// - One width per port for all queues
// - Per-queue full kept, selected one shown
// - Select edge, flag shows new queue next edge
// - Writes allowed from second edge after select
// - Full flag changes only on clock edges
// - Reads update full status of unselected queues
// - Flag released when no local queue selected
// - Flag driven only on chip code match
// - Controller ties flags, writes one device
// - Same-device switches keep driving, update flag
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "mqfc_defs.svh"
module mqfc_device
   import mqfc_pkg::*;
#(
   parameter int          DEPTH     = `MQFC_DEPTH,
   parameter logic [2:0]  CHIP_CODE = `MQFC_CHIP_CODE
)(
   // Clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // Link
   mqfc_link_if.device link,
   // Chip code straps
   input  wire logic chip_code_pin0,
   input  wire logic chip_code_pin1,
   input  wire logic chip_code_pin2,
   // Almost-full bus ownership
   output logic      almost_full_bus_owner
);
   localparam int PW = $clog2(DEPTH);
   // Lane counters wrap exactly at the queue size in lanes
   localparam int UW = $clog2(DEPTH) + 2;

   // Memory holds write-width-sized units in 9-bit lanes, four lanes per long word
   logic [8:0]    mem_q [`MQFC_NQUEUE][DEPTH*4];
   logic [UW-1:0] wcnt_q [`MQFC_NQUEUE];
   logic [UW-1:0] rcnt_q [`MQFC_NQUEUE];
   logic [UW:0]   fill_q [`MQFC_NQUEUE];
   mqfc_width_t   in_w_q;
   mqfc_width_t   out_w_q;
   logic [2:0]    wq_q;
   logic          sel_q;
   logic          sel_age_q;
   logic [2:0]    rq_q;
   logic          rsel_q;
   logic          full_q;
   logic          full_oe_q;
   logic [35:0]   rdata_q;
   logic          rvalid_q;
   logic [2:0]    code;
   logic          hit;
   logic          rhit;

   assign code = {chip_code_pin2, chip_code_pin1, chip_code_pin0};
   assign hit  = link.write_queue_address[5:3] == code;
   assign rhit = link.read_queue_address == code;

   function automatic logic [2:0] lanes(input mqfc_width_t w);
      unique case (w)
         MQFC_W36: lanes = 3'h4;
         MQFC_W18: lanes = 3'h2;
         MQFC_W9:  lanes = 3'h1;
         default:  lanes = 3'h4;
      endcase
   endfunction

   // Widths are static after master reset, shared by all queues
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         in_w_q  <= MQFC_W36;
         out_w_q <= MQFC_W36;
      end
      else if (link.master_reset)
      begin
         if (!link.width_matching_select)
         begin
            in_w_q  <= MQFC_W36;
            out_w_q <= MQFC_W36;
         end
         else
         begin
            unique case ({link.input_width_select, link.output_width_select})
               2'b00: begin in_w_q <= MQFC_W36; out_w_q <= MQFC_W18; end
               2'b01: begin in_w_q <= MQFC_W36; out_w_q <= MQFC_W9;  end
               2'b10: begin in_w_q <= MQFC_W18; out_w_q <= MQFC_W36; end
               2'b11: begin in_w_q <= MQFC_W9;  out_w_q <= MQFC_W36; end
            endcase
         end
      end
   end

   // Write queue selection
   always_ff @(posedge clk)
   begin
      if (srst || link.master_reset)
      begin
         wq_q      <= 3'h0;
         sel_q     <= 1'b0;
         sel_age_q <= 1'b0;
      end
      else if (link.write_address_enable)
      begin
         wq_q      <= link.write_queue_address[2:0];
         sel_q     <= hit;
         sel_age_q <= 1'b0;
      end
      else
         sel_age_q <= 1'b1;
   end

   // Read queue selection
   always_ff @(posedge clk)
   begin
      if (srst || link.master_reset)
      begin
         rq_q   <= 3'h0;
         rsel_q <= 1'b0;
      end
      else if (link.read_address_enable)
      begin
         // Host selects both ports at once; queue index rides on the write address
         rq_q   <= link.write_queue_address[2:0];
         rsel_q <= rhit;
      end
   end

   logic wr_go;
   logic rd_go;
   logic [2:0] wl;
   logic [2:0] rl;
   assign wl = lanes(in_w_q);
   assign rl = lanes(out_w_q);
   // Fill counted in 9-bit lanes; full means no room for one write unit
   assign wr_go = link.write_enable && sel_q && sel_age_q && !link.write_address_enable
                  && (fill_q[wq_q] + {{UW-2{1'b0}}, wl} <= (UW+1)'(DEPTH*4));
   assign rd_go = link.read_enable && rsel_q && (fill_q[rq_q] >= {{UW-2{1'b0}}, rl});

   // Little-endian lanes: first narrow unit lands in the low lanes
   always_ff @(posedge clk)
   begin
      if (wr_go)
      begin
         for (int i = 0; i < 4; i++)
            if (i < int'(wl))
               mem_q[wq_q][int'(wcnt_q[wq_q]) + i] <= link.write_data[i*9 +: 9];
      end
   end

   genvar g;
   generate
      for (g = 0; g < `MQFC_NQUEUE; g++)
      begin : g_q
         always_ff @(posedge clk)
         begin
            if (srst || link.master_reset)
            begin
               wcnt_q[g] <= '0;
               rcnt_q[g] <= '0;
               fill_q[g] <= '0;
            end
            else
            begin
               if (wr_go && wq_q == 3'(g))
                  wcnt_q[g] <= wcnt_q[g] + UW'(wl);
               if (rd_go && rq_q == 3'(g))
                  rcnt_q[g] <= rcnt_q[g] + UW'(rl);
               fill_q[g] <= fill_q[g]
                            + ((wr_go && wq_q == 3'(g)) ? (UW+1)'(wl) : '0)
                            - ((rd_go && rq_q == 3'(g)) ? (UW+1)'(rl) : '0);
            end
         end
      end
   endgenerate

   // Read data out; unused high lanes read as zero
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rdata_q  <= 36'h000000000;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= rd_go;
         if (rd_go)
            for (int i = 0; i < 4; i++)
               rdata_q[i*9 +: 9] <= (i < int'(rl)) ? mem_q[rq_q][int'(rcnt_q[rq_q]) + i] : 9'h000;
      end
   end

   // Full flag: active low, registered, tracks selected queue
   logic [UW:0] fill_next;
   assign fill_next = fill_q[link.write_address_enable ? link.write_queue_address[2:0] : wq_q];
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         full_q    <= 1'b1;
         full_oe_q <= 1'b0;
      end
      else
      begin
         // Look-ahead on the updated count keeps the flag exact one edge after select
         full_q    <= !(fill_next + ((wr_go) ? (UW+1)'(wl) : '0) - ((rd_go && rq_q == wq_q) ? (UW+1)'(rl) : '0)
                        + (UW+1)'(wl) > (UW+1)'(DEPTH*4));
         // Master reset deselects, so the line is released with it
         full_oe_q <= link.master_reset ? 1'b0 : (link.write_address_enable ? hit : sel_q);
      end
   end

   assign link.full_flag_o     = full_q;
   assign link.full_flag_oe    = full_oe_q;
   assign link.read_data       = rdata_q;
   assign link.read_data_valid = rvalid_q;
   assign almost_full_bus_owner = link.almost_full_bus_strobe && hit;
endmodule
`default_nettype wire

// File: logic/mqfc_host.sv
// System controller end: Avalon-MM slave steering write and read ports
`timescale 1ns/1ns
`default_nettype none
`include "mqfc_defs.svh"
module mqfc_host
   import mqfc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Link
   mqfc_link_if.host        link
);
   logic [5:0]  qaddr_q;
   logic [3:0]  cfg_q;
   logic        sel_pulse_q;
   logic        rsel_pulse_q;
   logic        wr_pulse_q;
   logic        rd_pulse_q;
   logic        strobe_q;
   logic [35:0] wdata_q;
   logic [35:0] rdata_q;
   logic        rvalid_q;
   logic [31:0] rd_q;
   logic        ack_q;
   logic        busy_q;
   logic [1:0]  age_q;

   // One-cycle answer: waitrequest drops the cycle after the request
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

   always_ff @(posedge clk)
   begin
      if (srst)
         ack_q <= 1'b0;
      else
         ack_q <= (avs_read || avs_write) && !ack_q;
   end

   // Ctrl: [5:0] queue addr, [8] select, [9] write, [10] read, [11] strobe, [14:12] width cfg, [15] mreset
   // Writes land only at the edge where waitrequest is low
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         qaddr_q <= 6'h00; cfg_q <= 4'h0; wdata_q <= 36'h000000000;
         sel_pulse_q <= 1'b0; rsel_pulse_q <= 1'b0; wr_pulse_q <= 1'b0; rd_pulse_q <= 1'b0; strobe_q <= 1'b0;
      end
      else
      begin
         sel_pulse_q <= 1'b0; rsel_pulse_q <= 1'b0; wr_pulse_q <= 1'b0; rd_pulse_q <= 1'b0;
         if (avs_write && ack_q && avs_address == `MQFC_CSR_CTRL)
         begin
            qaddr_q      <= avs_writedata[5:0];
            sel_pulse_q  <= avs_writedata[8];
            rsel_pulse_q <= avs_writedata[8];
            // Writing too soon after a switch is held off, not sent
            wr_pulse_q   <= avs_writedata[9] && !busy_q && age_q == 2'h2;
            rd_pulse_q   <= avs_writedata[10];
            strobe_q     <= avs_writedata[11];
            cfg_q        <= avs_writedata[15:12];
         end
         if (avs_write && ack_q && avs_address == `MQFC_CSR_WDATA)
            wdata_q <= {4'h0, avs_writedata};
      end
   end

   // Cycles since last select, saturating at two
   always_ff @(posedge clk)
   begin
      if (srst)
         age_q <= 2'h0;
      else if (sel_pulse_q)
         age_q <= 2'h0;
      else if (age_q != 2'h2)
         age_q <= age_q + 2'h1;
   end

   assign busy_q = !link.full_line;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rdata_q  <= 36'h000000000;
         rvalid_q <= 1'b0;
      end
      else if (link.read_data_valid)
      begin
         rdata_q  <= link.read_data;
         rvalid_q <= 1'b1;
      end
      else if (avs_read && ack_q && avs_address == `MQFC_CSR_RDATA)
         rvalid_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         rd_q <= 32'h00000000;
      else
         unique case (avs_address)
            `MQFC_CSR_CTRL:   rd_q <= {16'h0000, cfg_q, 6'h00, qaddr_q};
            `MQFC_CSR_STATUS: rd_q <= {28'h0000000, age_q, rvalid_q, !link.full_line};
            `MQFC_CSR_WDATA:  rd_q <= wdata_q[31:0];
            `MQFC_CSR_RDATA:  rd_q <= rdata_q[31:0];
            default:          rd_q <= 32'h00000000;
         endcase
   end
   assign avs_readdata = rd_q;

   assign link.write_queue_address    = qaddr_q;
   assign link.write_address_enable   = sel_pulse_q;
   assign link.write_enable           = wr_pulse_q;
   assign link.write_data             = wdata_q;
   assign link.read_queue_address     = qaddr_q[5:3];
   assign link.read_address_enable    = rsel_pulse_q;
   assign link.read_enable            = rd_pulse_q;
   assign link.almost_full_bus_strobe = strobe_q;
   assign link.width_matching_select  = cfg_q[0];
   assign link.input_width_select     = cfg_q[1];
   assign link.output_width_select    = cfg_q[2];
   assign link.master_reset           = cfg_q[3];
endmodule
`default_nettype wire

// File: logic/mqfc_link_if.sv
// Interface joining the system controller to the multi-queue device
`timescale 1ns/1ns
`default_nettype none
interface mqfc_link_if;
   logic [5:0]  write_queue_address;
   logic        write_address_enable;
   logic        write_enable;
   logic [35:0] write_data;
   logic [2:0]  read_queue_address;
   logic        read_address_enable;
   logic        read_enable;
   logic [35:0] read_data;
   logic        read_data_valid;
   logic        full_flag_o;
   logic        full_flag_oe;
   logic        almost_full_bus_strobe;
   logic        width_matching_select;
   logic        input_width_select;
   logic        output_width_select;
   logic        master_reset;
   // Shared full line: pulled high when no device drives it
   wire         full_line = full_flag_oe ? full_flag_o : 1'b1;
   modport device (input write_queue_address, write_address_enable, write_enable, write_data,
                   read_queue_address, read_address_enable, read_enable, almost_full_bus_strobe,
                   width_matching_select, input_width_select, output_width_select, master_reset,
                   output read_data, read_data_valid, full_flag_o, full_flag_oe);
   modport host (output write_queue_address, write_address_enable, write_enable, write_data,
                 read_queue_address, read_address_enable, read_enable, almost_full_bus_strobe,
                 width_matching_select, input_width_select, output_width_select, master_reset,
                 input read_data, read_data_valid, full_line);
endinterface
`default_nettype wire

// File: logic/mqfc_pkg.sv
// Types shared by both ends of the multi-queue link
package mqfc_pkg;
   typedef enum logic [1:0] {MQFC_W36, MQFC_W18, MQFC_W9} mqfc_width_t;
endpackage
